// [core/tfu_pkg.sv]
// Constants, types and access checks shared by the translation fault unit
package tfu_pkg;
  localparam int TB_ENTRIES = 32;
  localparam int TB_IDX_W = 5;
  localparam int VPN_W = 20;
  localparam int PAGE_W = 12;
  localparam int DOM_W = 4;
  localparam int CTRL_MMU = 0;
  localparam int CTRL_DC = 2;
  localparam int CTRL_WB = 3;
  localparam int CTRL_IC = 12;
  localparam int MINI_SETS = 8;
  localparam int MINI_SET_W = 3;
  localparam int MINI_WAYS = 2;
  localparam int LINE_OFF = 5;
  localparam int WORD_OFF = 2;
  localparam int LINE_WORDS_W = 3;
  localparam int FETCH_LAG = 3;
  localparam int TAG_LO = LINE_OFF + MINI_SET_W;
  localparam logic [LINE_WORDS_W-1:0] LAST_WORD = 3'h7;
  localparam logic [LINE_OFF-1:0] LINE_ZERO = 5'h0;
  localparam logic [1:0] DAC_CLIENT = 2'h1;
  localparam logic [1:0] DAC_MANAGER = 2'h3;
  localparam logic [1:0] AP_PRIV = 2'h1;
  localparam logic [1:0] AP_USER_RO = 2'h2;
  localparam logic [1:0] AP_FULL = 2'h3;

  typedef enum logic [1:0] {SZ_BYTE = 2'h0, SZ_HALF = 2'h1, SZ_WORD = 2'h2} size_type;
  typedef enum logic [2:0] {
    F_NONE = 3'h0, F_ALIGN = 3'h1, F_TRANS = 3'h2, F_DOMAIN = 3'h3,
    F_PERM = 3'h4, F_EXT = 3'h5, F_RESV = 3'h6
  } fault_type;

  typedef struct packed {
    logic [VPN_W-1:0] vpn;
    logic [VPN_W-1:0] ppn;
    logic [DOM_W-1:0] dom;
    logic [1:0] ap;
    logic bufferable;
    logic cacheable;
  } tb_entry_type;

  function automatic logic misaligned(size_type sz, logic [1:0] lsb);
    return (sz == SZ_WORD && lsb != 2'h0) || (sz == SZ_HALF && lsb[0]);
  endfunction

  // Manager domains skip page protection; reserved domain codes fault
  function automatic fault_type check_access(tb_entry_type e, logic [31:0] dacr, logic priv, logic wr);
    logic [1:0] dac;
    dac = dacr[{e.dom, 1'b0} +: 2];
    if (dac == DAC_MANAGER) return F_NONE;
    if (dac != DAC_CLIENT) return F_DOMAIN;
    if (e.ap == AP_FULL) return F_NONE;
    if (e.ap == AP_USER_RO) return (priv || !wr) ? F_NONE : F_PERM;
    if (e.ap == AP_PRIV) return priv ? F_NONE : F_PERM;
    return F_PERM;
  endfunction
endpackage

// [core/tb_port_if.sv]
// Lookup, refill and flush port of one translation buffer
`timescale 1ns/1ps
interface tb_port_if;
  import tfu_pkg::*;
  logic [VPN_W-1:0] look_vpn;
  logic hit;
  tb_entry_type hit_entry;
  logic fill;
  tb_entry_type fill_entry;
  logic flush;
  modport array (input look_vpn, input fill, input fill_entry, input flush, output hit, output hit_entry);
  modport user (output look_vpn, output fill, output fill_entry, output flush, input hit, input hit_entry);
endinterface

// [core/tb_array.sv]
// Fully associative translation buffer with round-robin refill
`timescale 1ns/1ps
module tb_array (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  tb_port_if.array tb_port
);
  import tfu_pkg::*;
  tb_entry_type entry_q [TB_ENTRIES];
  logic [TB_ENTRIES-1:0] valid_q;
  logic [TB_IDX_W-1:0] rr_q;

  always_comb begin
    tb_port.hit = 1'b0;
    tb_port.hit_entry = '0;
    for (int i = 0; i < TB_ENTRIES; i++) begin
      if (valid_q[i] && entry_q[i].vpn == tb_port.look_vpn) begin
        tb_port.hit = 1'b1;
        tb_port.hit_entry = entry_q[i];
      end
    end
  end

  // Only a flush or reset clears entries; switching translation off leaves them intact
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      valid_q <= '0;
    end else if (tb_port.flush) begin
      valid_q <= '0;
    end else if (tb_port.fill) begin
      valid_q[rr_q] <= 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      rr_q <= '0;
    end else if (tb_port.fill) begin
      rr_q <= rr_q + 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (tb_port.fill) begin
      entry_q[rr_q] <= tb_port.fill_entry;
    end
  end

  a_rr_advance: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    tb_port.fill |=> rr_q == $past(rr_q) + 1'b1) else $error("victim pointer did not advance");
  a_flush_clears: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    tb_port.flush |=> valid_q == '0) else $error("flush left valid entries");
endmodule

// [core/mini_dcache.sv]
// Two-way set associative tag store of the secondary data cache
`timescale 1ns/1ps
module mini_dcache (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic [31:0] i_look_addr,
  output logic o_hit,
  input wire logic i_alloc,
  input wire logic i_inval,
  input wire logic [31:0] i_line_addr
);
  import tfu_pkg::*;
  logic [31-TAG_LO:0] tag_q [MINI_SETS][MINI_WAYS];
  logic [MINI_WAYS-1:0] valid_q [MINI_SETS];
  logic [MINI_SETS-1:0] victim_q;
  logic [MINI_SET_W-1:0] set_a;

  function automatic logic [MINI_SET_W-1:0] set_of(logic [31:0] a);
    return a[LINE_OFF +: MINI_SET_W];
  endfunction

  function automatic logic present(logic [31:0] a, int w, logic [MINI_WAYS-1:0] v, logic [31-TAG_LO:0] t);
    return v[w] && t == a[31:TAG_LO];
  endfunction

  assign set_a = set_of(i_line_addr);

  always_comb begin
    o_hit = 1'b0;
    for (int w = 0; w < MINI_WAYS; w++) begin
      if (present(i_look_addr, w, valid_q[set_of(i_look_addr)], tag_q[set_of(i_look_addr)][w])) begin
        o_hit = 1'b1;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      for (int s = 0; s < MINI_SETS; s++) begin
        valid_q[s] <= '0;
      end
      victim_q <= '0;
    end else if (i_alloc) begin
      valid_q[set_a][victim_q[set_a]] <= 1'b1;
      victim_q[set_a] <= ~victim_q[set_a];
    end else if (i_inval) begin
      for (int w = 0; w < MINI_WAYS; w++) begin
        if (present(i_line_addr, w, valid_q[set_a], tag_q[set_a][w])) begin
          valid_q[set_a][w] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_alloc) begin
      tag_q[set_a][victim_q[set_a]] <= i_line_addr[31:TAG_LO];
    end
  end
endmodule

// [core/translation_buffer_fault_unit.sv]
// Address translation, access checking and abort handling for the core
//
// What this block does
// - Two 32-entry fully associative buffers: one for fetches, one for data.
// - On a buffer miss, run the table walk and install the valid result.
// - Refill victim entry is chosen round-robin.
// - Invalid page or section from the walk aborts and installs nothing.
// - Word access with either low address bit set gives alignment fault.
// - Halfword access with address bit 0 set gives alignment fault.
// - Access to a page marked invalid gives a translation fault.
// - Mode, domain or page protection violations give domain or permission faults.
// - Data abort on translation fault, reserved space, or external abort input.
// - External abort is ignored for bufferable writes.
// - Abort on any word of a line fill discards the partial line.
// - Fill abort before the requested word returns aborts the load.
// - Fill abort after the requested word completes the load, no exception.
// - Control bits: 0 translation, 2 data cache, 3 write buffer, 12 icache.
// - Three already-fetched instructions keep the old mapping after a switch.
// - Buffer contents survive translation being disabled and re-enabled.
// - Secondary data cache: 16 entries, two-way, looked up in parallel.
// - A line never sits in both data caches at once.
// - With the write buffer disabled, writes count as non-bufferable.
`timescale 1ns/1ps
module translation_buffer_fault_unit (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic [31:0] i_ctrl,
  input wire logic [31:0] i_dacr,
  input wire logic i_priv,
  input wire logic i_flush_itb,
  input wire logic i_flush_dtb,
  input wire logic i_fetch_req,
  input wire logic [31:0] i_fetch_vaddr,
  output logic o_fetch_done,
  output logic o_fetch_abort,
  output tfu_pkg::fault_type o_fetch_fault_type,
  output logic [31:0] o_fetch_paddr,
  input wire logic i_data_req,
  input wire logic [31:0] i_data_vaddr,
  input wire logic i_data_write,
  input wire tfu_pkg::size_type i_data_size,
  input wire logic [31:0] i_data_wdata,
  input wire logic i_data_reserved,
  output logic o_data_done,
  output logic o_data_abort,
  output tfu_pkg::fault_type o_data_fault_type,
  output logic [31:0] o_data_rdata,
  output logic o_data_mini_hit,
  output logic o_walk_req,
  output logic o_walk_instr,
  output logic [31:0] o_walk_vaddr,
  input wire logic i_walk_done,
  input wire logic i_walk_valid,
  input wire tfu_pkg::tb_entry_type i_walk_entry,
  output logic o_bus_req,
  output logic [31:0] o_bus_addr,
  output logic o_bus_write,
  output logic [31:0] o_bus_wdata,
  output logic o_bus_line,
  input wire logic i_bus_ack,
  input wire logic i_bus_abort,
  input wire logic [31:0] i_bus_rdata,
  output logic o_fill_discard,
  output logic o_main_alloc,
  output logic o_main_inval,
  output logic [31:0] o_line_addr,
  output logic o_icache_en,
  output logic o_dcache_en,
  output logic o_wb_en
);
  import tfu_pkg::*;

  typedef enum logic [3:0] {D_IDLE = 4'h1, D_CHK = 4'h2, D_WALK = 4'h4, D_BUS = 4'h8} dstate_type;
  typedef enum logic [2:0] {I_IDLE = 3'h1, I_CHK = 3'h2, I_WALK = 3'h4} istate_type;

  dstate_type d_state_q;
  istate_type i_state_q;
  logic [31:0] req_vaddr_q;
  logic req_write_q;
  size_type req_size_q;
  logic [31:0] req_wdata_q;
  logic req_resv_q;
  logic [31:0] fetch_vaddr_q;
  logic fetch_map_q;
  logic [FETCH_LAG-1:0] imap_q;
  logic bus_buf_q;
  logic mini_q;
  logic served_q;
  logic mini_alloc_q;
  logic [LINE_WORDS_W-1:0] word_cnt_q;
  logic mmu_on;
  logic d_need_walk;
  logic i_grant;
  logic mini_hit;
  logic chk_buf;
  logic chk_cache;
  logic chk_mini;
  logic [31:0] chk_paddr;
  fault_type chk_fault;
  fault_type i_fault;

  tb_port_if itb ();
  tb_port_if dtb ();

  // ==========================================================
  // Translation buffers and secondary cache tags
  tb_array u_itb (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .tb_port(itb));
  tb_array u_dtb (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .tb_port(dtb));

  mini_dcache u_mini (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_look_addr(chk_paddr),
    .o_hit(mini_hit),
    .i_alloc(mini_alloc_q),
    .i_inval(o_main_alloc),
    .i_line_addr(o_line_addr)
  );

  assign itb.look_vpn = fetch_vaddr_q[31:PAGE_W];
  assign dtb.look_vpn = req_vaddr_q[31:PAGE_W];
  assign itb.fill_entry = i_walk_entry;
  assign dtb.fill_entry = i_walk_entry;
  assign itb.flush = i_flush_itb;
  assign dtb.flush = i_flush_dtb;
  assign itb.fill = o_walk_req && o_walk_instr && i_walk_done && i_walk_valid;
  assign dtb.fill = o_walk_req && !o_walk_instr && i_walk_done && i_walk_valid;

  // ==========================================================
  // Enables
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_icache_en <= 1'b0;
      o_dcache_en <= 1'b0;
      o_wb_en <= 1'b0;
    end else begin
      o_icache_en <= i_ctrl[CTRL_IC];
      o_dcache_en <= i_ctrl[CTRL_DC];
      o_wb_en <= i_ctrl[CTRL_WB];
    end
  end

  // Illegal enable mixes are not interlocked; software keeps them legal
  assign mmu_on = i_ctrl[CTRL_MMU];

  // ==========================================================
  // Data access check
  always_comb begin
    chk_fault = F_NONE;
    if (misaligned(req_size_q, req_vaddr_q[1:0])) begin
      chk_fault = F_ALIGN;
    end else if (req_resv_q) begin
      chk_fault = F_RESV;
    end else if (mmu_on && dtb.hit) begin
      chk_fault = check_access(dtb.hit_entry, i_dacr, i_priv, req_write_q);
    end
  end

  assign chk_paddr = mmu_on ? {dtb.hit_entry.ppn, req_vaddr_q[PAGE_W-1:0]} : req_vaddr_q;
  assign chk_buf = mmu_on && dtb.hit_entry.bufferable && i_ctrl[CTRL_WB];
  assign chk_cache = mmu_on && dtb.hit_entry.cacheable && i_ctrl[CTRL_DC];
  assign chk_mini = chk_cache && !dtb.hit_entry.bufferable;
  assign d_need_walk = mmu_on && !dtb.hit && chk_fault == F_NONE;
  assign i_grant = !o_walk_req && !(d_state_q == D_CHK && d_need_walk);

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      req_vaddr_q <= '0;
      req_write_q <= 1'b0;
      req_size_q <= SZ_WORD;
      req_wdata_q <= '0;
      req_resv_q <= 1'b0;
    end else if (d_state_q == D_IDLE && i_data_req) begin
      req_vaddr_q <= i_data_vaddr;
      req_write_q <= i_data_write;
      req_size_q <= i_data_size;
      req_wdata_q <= i_data_wdata;
      req_resv_q <= i_data_reserved;
    end
  end

  // ==========================================================
  // Table walk request, shared; data side wins a tie
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_walk_req <= 1'b0;
      o_walk_instr <= 1'b0;
      o_walk_vaddr <= '0;
    end else if (o_walk_req) begin
      if (i_walk_done) begin
        o_walk_req <= 1'b0;
      end
    end else if (d_state_q == D_CHK && d_need_walk) begin
      o_walk_req <= 1'b1;
      o_walk_instr <= 1'b0;
      o_walk_vaddr <= req_vaddr_q;
    end else if (i_state_q == I_CHK && fetch_map_q && !itb.hit) begin
      o_walk_req <= 1'b1;
      o_walk_instr <= 1'b1;
      o_walk_vaddr <= fetch_vaddr_q;
    end
  end

  // ==========================================================
  // Data side sequencing and external bus
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      d_state_q <= D_IDLE;
      o_data_done <= 1'b0;
      o_data_abort <= 1'b0;
      o_data_fault_type <= F_NONE;
      o_data_rdata <= '0;
      o_data_mini_hit <= 1'b0;
      o_bus_req <= 1'b0;
      o_bus_addr <= '0;
      o_bus_write <= 1'b0;
      o_bus_wdata <= '0;
      o_bus_line <= 1'b0;
      bus_buf_q <= 1'b0;
      mini_q <= 1'b0;
      served_q <= 1'b0;
      word_cnt_q <= '0;
      o_fill_discard <= 1'b0;
      o_main_alloc <= 1'b0;
      o_main_inval <= 1'b0;
      mini_alloc_q <= 1'b0;
      o_line_addr <= '0;
    end else begin
      o_data_done <= 1'b0;
      o_data_abort <= 1'b0;
      o_fill_discard <= 1'b0;
      o_main_alloc <= 1'b0;
      o_main_inval <= 1'b0;
      mini_alloc_q <= 1'b0;
      unique case (d_state_q)
        D_IDLE: begin
          if (i_data_req) begin
            d_state_q <= D_CHK;
          end
        end
        D_CHK: begin
          if (chk_fault != F_NONE) begin
            o_data_done <= 1'b1;
            o_data_abort <= 1'b1;
            o_data_fault_type <= chk_fault;
            d_state_q <= D_IDLE;
          end else if (d_need_walk) begin
            if (!o_walk_req) begin
              d_state_q <= D_WALK;
            end
          end else begin
            o_bus_req <= 1'b1;
            o_bus_addr <= chk_paddr;
            o_bus_write <= req_write_q;
            o_bus_wdata <= req_wdata_q;
            // A line already in the secondary cache is not fetched again
            o_bus_line <= chk_cache && !req_write_q && !mini_hit;
            o_data_mini_hit <= mini_hit;
            bus_buf_q <= chk_buf && req_write_q;
            mini_q <= chk_mini;
            served_q <= chk_buf && req_write_q;
            word_cnt_q <= '0;
            o_data_fault_type <= F_NONE;
            o_data_done <= chk_buf && req_write_q;
            d_state_q <= D_BUS;
          end
        end
        D_WALK: begin
          if (i_walk_done && !o_walk_instr) begin
            if (i_walk_valid) begin
              d_state_q <= D_CHK;
            end else begin
              o_data_done <= 1'b1;
              o_data_abort <= 1'b1;
              o_data_fault_type <= F_TRANS;
              d_state_q <= D_IDLE;
            end
          end
        end
        D_BUS: begin
          if (i_bus_ack) begin
            word_cnt_q <= word_cnt_q + 1'b1;
            if (i_bus_abort && !bus_buf_q) begin
              o_bus_req <= 1'b0;
              d_state_q <= D_IDLE;
              o_fill_discard <= o_bus_line;
              if (!served_q) begin
                o_data_done <= 1'b1;
                o_data_abort <= 1'b1;
                o_data_fault_type <= F_EXT;
              end
            end else begin
              if (!served_q && (!o_bus_line || word_cnt_q == req_vaddr_q[LINE_OFF-1:WORD_OFF])) begin
                served_q <= 1'b1;
                o_data_rdata <= i_bus_rdata;
                o_data_done <= 1'b1;
              end
              if (!o_bus_line || word_cnt_q == LAST_WORD) begin
                o_bus_req <= 1'b0;
                d_state_q <= D_IDLE;
                if (o_bus_line) begin
                  o_line_addr <= {o_bus_addr[31:LINE_OFF], LINE_ZERO};
                  o_main_alloc <= !mini_q;
                  o_main_inval <= mini_q;
                  mini_alloc_q <= mini_q;
                end
              end
            end
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Fetch side; mapping switches only after three more fetches
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      imap_q <= '0;
      fetch_map_q <= 1'b0;
      fetch_vaddr_q <= '0;
    end else if (i_state_q == I_IDLE && i_fetch_req) begin
      imap_q <= {imap_q[FETCH_LAG-2:0], i_ctrl[CTRL_MMU]};
      fetch_map_q <= imap_q[FETCH_LAG-1];
      fetch_vaddr_q <= i_fetch_vaddr;
    end
  end

  assign i_fault = check_access(itb.hit_entry, i_dacr, i_priv, 1'b0);

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      i_state_q <= I_IDLE;
      o_fetch_done <= 1'b0;
      o_fetch_abort <= 1'b0;
      o_fetch_fault_type <= F_NONE;
      o_fetch_paddr <= '0;
    end else begin
      o_fetch_done <= 1'b0;
      o_fetch_abort <= 1'b0;
      unique case (i_state_q)
        I_IDLE: begin
          if (i_fetch_req) begin
            i_state_q <= I_CHK;
          end
        end
        I_CHK: begin
          if (!fetch_map_q || itb.hit) begin
            o_fetch_done <= 1'b1;
            o_fetch_paddr <= fetch_map_q ? {itb.hit_entry.ppn, fetch_vaddr_q[PAGE_W-1:0]} : fetch_vaddr_q;
            o_fetch_fault_type <= fetch_map_q ? i_fault : F_NONE;
            o_fetch_abort <= fetch_map_q && i_fault != F_NONE;
            i_state_q <= I_IDLE;
          end else if (i_grant) begin
            i_state_q <= I_WALK;
          end
        end
        I_WALK: begin
          if (i_walk_done && o_walk_instr) begin
            if (i_walk_valid) begin
              i_state_q <= I_CHK;
            end else begin
              o_fetch_done <= 1'b1;
              o_fetch_abort <= 1'b1;
              o_fetch_fault_type <= F_TRANS;
              i_state_q <= I_IDLE;
            end
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);

  a_align_word: assert property (d_state_q == D_CHK && req_size_q == SZ_WORD && req_vaddr_q[1:0] != 2'h0
    |=> o_data_abort && o_data_fault_type == F_ALIGN) else $error("misaligned word not faulted");
  a_align_half: assert property (d_state_q == D_CHK && req_size_q == SZ_HALF && req_vaddr_q[0]
    |=> o_data_abort && o_data_fault_type == F_ALIGN) else $error("misaligned halfword not faulted");
  a_walk_miss: assert property (d_state_q == D_CHK && d_need_walk && !o_walk_req
    |=> o_walk_req && !o_walk_instr ##0 d_state_q == D_WALK) else $error("miss did not start walk");
  a_no_install: assert property (o_walk_req && i_walk_done && !i_walk_valid
    |-> !dtb.fill && !itb.fill) else $error("invalid walk installed entry");
  a_invalid_page: assert property (d_state_q == D_WALK && i_walk_done && !i_walk_valid && !o_walk_instr
    |=> o_data_done && o_data_abort && o_data_fault_type == F_TRANS) else $error("invalid page not faulted");
  a_bufwr_noabort: assert property (d_state_q == D_BUS && bus_buf_q && i_bus_ack && i_bus_abort
    |=> !o_data_abort && !o_data_done) else $error("buffered write aborted");
  a_fill_discard: assert property (d_state_q == D_BUS && o_bus_line && i_bus_ack && i_bus_abort
    |=> o_fill_discard && !o_main_alloc && !o_main_inval) else $error("aborted fill kept");
  a_early_abort: assert property (d_state_q == D_BUS && o_bus_line && i_bus_ack && i_bus_abort && !served_q
    |=> o_data_abort && o_data_fault_type == F_EXT) else $error("early fill abort not raised");
  a_late_abort: assert property (d_state_q == D_BUS && o_bus_line && i_bus_ack && i_bus_abort && served_q
    |=> !o_data_abort ##1 !o_data_abort) else $error("late fill abort raised exception");
  a_mini_excl: assert property (d_state_q == D_BUS && o_bus_line && i_bus_ack && !i_bus_abort
    && word_cnt_q == LAST_WORD |=> o_main_alloc != o_main_inval) else $error("line allocated to both caches");
endmodule

// [tb/mem_partner.sv]
// Table walker and memory bus model facing the translation fault unit
`timescale 1ns/1ps
module mem_partner import tfu_pkg::*; (
  input wire logic i_sys_clk,
  input wire logic i_walk_req,
  input wire logic [31:0] i_walk_vaddr,
  input wire logic i_bad,
  input wire logic i_bus_req,
  input wire logic [31:0] i_bus_addr,
  input wire logic i_abt,
  output logic o_walk_done,
  output logic o_walk_valid,
  output tb_entry_type o_walk_entry,
  output logic o_bus_ack,
  output logic o_bus_abort,
  output logic [31:0] o_bus_rdata
);
  logic [1:0] wait_q;
  initial begin
    {wait_q, o_walk_done, o_walk_valid, o_walk_entry, o_bus_ack, o_bus_abort, o_bus_rdata} = '0;
  end
  // ====
  // Answers change after the falling edge; idle data lines toggle so stale values never match
  always @(negedge i_sys_clk) begin
    o_walk_done <= 1'b0;
    o_walk_valid <= ~o_walk_valid;
    o_bus_ack <= 1'b0;
    o_bus_abort <= 1'b0;
    o_bus_rdata <= ~o_bus_rdata;
    if (i_walk_req && !o_walk_done) begin
      wait_q <= wait_q + 2'h1;
      if (wait_q == 2'h2) begin
        wait_q <= 2'h0;
        o_walk_done <= 1'b1;
        o_walk_valid <= !i_bad;
        o_walk_entry <= '{vpn: i_walk_vaddr[31:12], ppn: i_walk_vaddr[31:12] + 20'h1, dom: 4'h0,
          ap: i_walk_vaddr[31] ? AP_PRIV : AP_FULL, bufferable: i_walk_vaddr[30], cacheable: i_walk_vaddr[29]};
      end
    end
    if (i_bus_req && !o_bus_ack) begin
      o_bus_ack <= 1'b1;
      o_bus_abort <= i_abt;
      o_bus_rdata <= i_bus_addr ^ 32'h5a5a5a5a;
    end
  end
endmodule

// [tb/testbench.sv]
// Self-checking bench for the data and fetch sides of the translation fault unit
`timescale 1ns/1ps
module testbench;
  import tfu_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, priv = 1'b1, flush = 1'b0, req = 1'b0, resv = 1'b0, bad = 1'b0, abt = 1'b0;
  logic [31:0] ctrl = 32'h0, dacr = 32'h1, vaddr = 32'h0, a, b;
  logic freq = 1'b0, wr = 1'b0, fdone, fabort;
  logic [31:0] fpaddr;
  fault_type ffault;
  size_type size = SZ_WORD;
  logic done, abort, walk_req, walk_done, walk_valid, bus_req, bus_ack, bus_abort;
  logic [31:0] rdata, walk_vaddr, bus_addr, bus_rdata;
  fault_type fault;
  tb_entry_type walk_entry;
  logic [36:0] notes[$], fnotes[$];
  int miscompares = 0, comparisons = 0, cyc = 0;
  translation_buffer_fault_unit DUT (.i_sys_clk(clk), .i_rst_n(rst_n), .i_ctrl(ctrl), .i_dacr(dacr),
    .i_priv(priv), .i_flush_itb(flush), .i_flush_dtb(flush), .i_fetch_req(freq), .i_fetch_vaddr(vaddr),
    .o_fetch_done(fdone), .o_fetch_abort(fabort), .o_fetch_fault_type(ffault), .o_fetch_paddr(fpaddr),
    .i_data_req(req), .i_data_vaddr(vaddr), .i_data_write(wr), .i_data_size(size), .i_data_wdata(32'h0),
    .i_data_reserved(resv), .o_data_done(done), .o_data_abort(abort), .o_data_fault_type(fault),
    .o_data_rdata(rdata), .o_data_mini_hit(), .o_walk_req(walk_req), .o_walk_instr(),
    .o_walk_vaddr(walk_vaddr), .i_walk_done(walk_done), .i_walk_valid(walk_valid),
    .i_walk_entry(walk_entry), .o_bus_req(bus_req), .o_bus_addr(bus_addr), .o_bus_write(),
    .o_bus_wdata(), .o_bus_line(), .i_bus_ack(bus_ack), .i_bus_abort(bus_abort), .i_bus_rdata(bus_rdata),
    .o_fill_discard(), .o_main_alloc(), .o_main_inval(), .o_line_addr(), .o_icache_en(), .o_dcache_en(),
    .o_wb_en());
  mem_partner partner (.i_sys_clk(clk), .i_walk_req(walk_req), .i_walk_vaddr(walk_vaddr), .i_bad(bad),
    .i_bus_req(bus_req), .i_bus_addr(bus_addr), .i_abt(abt), .o_walk_done(walk_done),
    .o_walk_valid(walk_valid), .o_walk_entry(walk_entry), .o_bus_ack(bus_ack), .o_bus_abort(bus_abort),
    .o_bus_rdata(bus_rdata));
  initial forever #5 clk = ~clk;
  // ====
  // Expectation notes: {data checked, abort, fault, read data}
  function automatic logic [36:0] md(logic [31:0] p);
    return {1'b1, 1'b0, F_NONE, p ^ 32'h5a5a5a5a};
  endfunction
  function automatic logic [36:0] flt(fault_type f);
    return {1'b0, 1'b1, f, 32'h0};
  endfunction
  function automatic logic [31:0] tr(logic [31:0] v);
    return {v[31:12] + 20'h1, v[11:0]};
  endfunction
  task automatic check(input logic [36:0] e, input logic [36:0] g);
    comparisons++;
    if (e !== g) begin
      miscompares++;
      $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic acc(input logic [31:0] v, input size_type s, input logic r, input logic [36:0] e);
    int k;
    vaddr = v;
    size = s;
    resv = r;
    req = 1'b1;
    notes.push_back(e);
    @(negedge clk) req = 1'b0;
    k = 0;
    while (done !== 1'b1 && k < 60) begin
      @(negedge clk);
      k++;
    end
    // Line fills and posted writes keep the data side busy after done
    while (bus_req === 1'b1) @(negedge clk);
    @(negedge clk);
  endtask
  task automatic fet(input logic [31:0] v, input logic [31:0] p);
    int k;
    vaddr = v;
    freq = 1'b1;
    fnotes.push_back({1'b1, 1'b0, F_NONE, p});
    @(negedge clk) freq = 1'b0;
    k = 0;
    while (fdone !== 1'b1 && k < 60) begin
      @(negedge clk);
      k++;
    end
    @(negedge clk);
  endtask
  task automatic check_fetch(input logic [36:0] e, input logic [36:0] g);
    comparisons++;
    if (e !== g) begin
      miscompares++;
      $display("ERROR t=%0t fetch exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic tally_and_finish;
    // A result that never came leaves its note behind
    miscompares += notes.size() + fnotes.size();
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  logic [36:0] n, fn;
  always @(negedge clk) if (done === 1'b1) begin
    n = notes.pop_front();
    check(n, {n[36], abort, fault, n[36] ? rdata : 32'h0});
  end
  always @(negedge clk) if (fdone === 1'b1) begin
    fn = fnotes.pop_front();
    check_fetch(fn, {1'b1, fabort, ffault, fpaddr});
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      miscompares++;
      tally_and_finish;
    end
  end
  // ====
  // Main sequence; domain setting is already in place before translation is switched on
  initial begin
    void'($urandom(32'h9a51370a));
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    a = $urandom & 32'h7ffffffc;
    b = a | 32'h80000000;
    acc(a, SZ_WORD, 1'b0, md(a));
    for (int i = 1; i < 4; i++) acc(a | i, SZ_WORD, 1'b0, flt(F_ALIGN));
    acc(a | 1, SZ_HALF, 1'b0, flt(F_ALIGN));
    acc(a | 2, SZ_HALF, 1'b0, md(a | 2));
    acc(a, SZ_WORD, 1'b1, flt(F_RESV));
    abt = 1'b1;
    acc(a, SZ_WORD, 1'b0, flt(F_EXT));
    abt = 1'b0;
    ctrl = 32'h1;
    bad = 1'b1;
    acc(a, SZ_WORD, 1'b0, flt(F_TRANS));
    bad = 1'b0;
    acc(a, SZ_WORD, 1'b0, md(tr(a)));
    ctrl = 32'h0;
    repeat (2) @(negedge clk);
    ctrl = 32'h1;
    bad = 1'b1;
    repeat (2) @(negedge clk);
    acc(a, SZ_WORD, 1'b0, md(tr(a)));
    dacr = 32'h0;
    acc(a, SZ_WORD, 1'b0, flt(F_DOMAIN));
    dacr = 32'h1;
    bad = 1'b0;
    priv = 1'b0;
    acc(b, SZ_WORD, 1'b0, flt(F_PERM));
    priv = 1'b1;
    acc(b, SZ_WORD, 1'b0, md(tr(b)));
    flush = 1'b1;
    @(negedge clk) flush = 1'b0;
    bad = 1'b1;
    acc(a, SZ_WORD, 1'b0, flt(F_TRANS));
    bad = 1'b0;
    // Fetch history is flat after reset, so the fourth fetch is the first translated one
    for (int i = 0; i < 4; i++) fet(a, i < 3 ? a : tr(a));
    wr = 1'b1;
    abt = 1'b1;
    b = a | 32'h40000000;
    acc(b, SZ_WORD, 1'b0, flt(F_EXT));
    ctrl = 32'h9;
    acc(b, SZ_WORD, 1'b0, 37'h0);
    wr = 1'b0;
    abt = 1'b0;
    ctrl = 32'hd;
    b = (a & 32'h9fffffff) | 32'h20000000;
    acc(b, SZ_WORD, 1'b0, md(tr(b)));
    acc(b, SZ_WORD, 1'b0, md(tr(b)));
    abt = 1'b1;
    acc(b ^ 32'h20, SZ_WORD, 1'b0, flt(F_EXT));
    abt = 1'b0;
    tally_and_finish;
  end
endmodule
